/* common/mwa_pkg.sv */
// package for the translation back end: register map, field layouts, encodings, types
// assumes one 200 MHz core clock, AXI4-Lite control port with 32-bit data
`default_nettype none
package mwa_pkg;
  localparam int unsigned CLK_MHZ       = 200;
  localparam logic [7:0] OFS_TCR        = 8'h00;
  localparam logic [7:0] OFS_TBC32      = 8'h04;
  localparam logic [7:0] OFS_VTCR       = 8'h08;
  localparam logic [7:0] OFS_ENV        = 8'h0C;
  localparam logic [7:0] OFS_WALK_ATTR  = 8'h10;
  localparam logic [7:0] OFS_HYP_ATTR   = 8'h14;
  localparam logic [7:0] OFS_S2_ATTR    = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1C;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h20;
  // translation control fields
  localparam int unsigned TCR_GRAN_LO_LSB  = 0;   // 2 bits
  localparam int unsigned TCR_GRAN_HI_LSB  = 2;   // 2 bits
  localparam int unsigned TCR_WALK_IN_LSB  = 4;   // 2 bits
  localparam int unsigned TCR_WALK_OUT_LSB = 6;   // 2 bits
  localparam int unsigned TCR_HA_BIT    = 8;
  localparam int unsigned TCR_HD_BIT    = 9;
  localparam int unsigned TCR_PB_LSB    = 10;  // 2 bits, attribute enables
  localparam int unsigned TBC_LDS_S_BIT = 0;
  localparam int unsigned TBC_LDS_NS_BIT= 1;
  localparam int unsigned ENV_A64_BIT   = 0;
  localparam int unsigned ENV_HYP_BIT   = 1;
  localparam int unsigned ENV_SEC_BIT   = 2;
  localparam int unsigned ENV_CACHE_BIT = 3;
  localparam int unsigned ENV_HIGH_BIT  = 4;   // second base register selected
  localparam int unsigned ENV_EL0_BIT   = 5;
  localparam int unsigned ENV_S2_BIT    = 6;
  localparam logic [1:0] RGN_WB         = 2'h1;
  localparam logic [5:0] FSC_UPDATE_ABT = 6'h31;  // 110001
  localparam logic [5:0] FSC_EXT_ABT    = 6'h10;
  localparam logic [5:0] FSC_ADDR_SIZE  = 6'h00;
  localparam logic [5:0] FSC_TRANS      = 6'h04;
  localparam logic [5:0] FSC_ACC_FLAG   = 6'h08;
  localparam logic [5:0] FSC_PERM       = 6'h0C;
  localparam logic [5:0] FSC_CONFLICT   = 6'h30;
  localparam logic [5:0] FSC_NONE       = 6'h00;
  localparam int unsigned PA_W          = 40;

  typedef enum logic [1:0] {
    MWA_G4K  = 2'b00,
    MWA_G64K = 2'b01,
    MWA_G16K = 2'b10,
    MWA_GRES = 2'b11
  } mwa_gran_e;

  typedef enum logic [2:0] {
    MWA_MEM_WB    = 3'b000,
    MWA_MEM_WT    = 3'b001,
    MWA_MEM_NC    = 3'b010,
    MWA_MEM_DEV_GATHER  = 3'b100,
    MWA_MEM_DEV_REORDER = 3'b101,
    MWA_MEM_DEV_EA      = 3'b110,
    MWA_MEM_NGNRN = 3'b111
  } mwa_mem_e;

  typedef enum logic [2:0] {
    MWA_SRC_NONE = 3'b000,
    MWA_SRC_L1   = 3'b001,
    MWA_SRC_L2   = 3'b010,
    MWA_SRC_WALK = 3'b011
  } mwa_src_e;

  typedef enum logic [1:0] {
    MWA_OP_LOAD = 2'b00,
    MWA_OP_STR  = 2'b01,
    MWA_OP_EXCL = 2'b10,
    MWA_OP_CAS  = 2'b11
  } mwa_op_e;

  // lookup result presented by the TLB / walker front
  typedef struct packed {
    logic             valid;
    mwa_src_e         src;
    logic             instr;
    logic             multi;
    logic [PA_W-1:0]  pa;
    logic [PA_W-1:0]  elem_addr;
    logic [2:0]       perm;
    logic [3:0]       domain;
    logic             ns;
    mwa_mem_e         in_type;
    logic [1:0]       out_rgn;
    logic [1:0]       s1_pb;
    logic [1:0]       s2_pb;
    logic             walk_err;
    logic             addr_size_flt;
    logic             trans_flt;
    logic             af_flt;
    logic             perm_flt;
    logic             conflict;
    logic             oversize;
    mwa_op_e          op;
    logic             dirty_mod;
    logic             ap2;
    logic             s2ap1;
    logic             op_fail;
    logic             tbl_wb;
  } mwa_req_s;

  typedef struct packed {
    logic             valid;
    logic [PA_W-1:0]  pa;
    logic [2:0]       perm;
    logic [3:0]       domain;
    logic             ns;
    logic             fault;
    logic [5:0]       fsc;
    logic [PA_W-1:0]  fault_addr;
    logic             cacheable;
    logic             coherent;
    logic             no_spec;
    logic [2:0]       bus_type;
    logic [1:0]       pb;
    logic             upd_s1;
    logic             upd_s2;
  } mwa_rsp_s;

  typedef struct packed {
    mwa_gran_e        gran;
    logic             long_desc;
    logic             walk_cacheable;
    logic [1:0]       walk_pb;
  } mwa_walk_s;
endpackage
`default_nettype wire

/* hw/mwa_top.sv */
// translation back end: walk setup, descriptor update decision, response and abort content
// assumes lookup results arrive one per cycle from same-clock logic, AXI4-Lite control port
`default_nettype none
module mwa_top
  import mwa_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  output var  logic [1:0]  BRESP,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  input  wire mwa_req_s    REQ,
  output var  mwa_rsp_s    RSP,
  output var  mwa_walk_s   WALK
);

  typedef struct packed {
    logic [31:0] tcr;
    logic [31:0] tbc;
    logic [31:0] vtcr;
    logic [31:0] env;
    logic [31:0] walk_attr;
    logic [31:0] hyp_attr;
    logic [31:0] s2_attr;
    logic [31:0] fault_addr;
    logic [5:0]  last_fsc;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    mwa_rsp_s    rsp;
    mwa_walk_s   walk;
  } mwa_state_s;

  mwa_state_s st;
  mwa_state_s next_st;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= OFS_FAULT_ADDR) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge_strb = r;
  endfunction

  function automatic logic both_wb(input logic [1:0] inner, input logic [1:0] outer);
    both_wb = (inner == RGN_WB) && (outer == RGN_WB);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic        wr_fire;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        a64;
  logic        hyp;
  logic        upd_en;
  logic        upd_req;
  logic        upd_abort;
  logic        hit_upd;
  logic [1:0]  s1_en;
  logic [1:0]  s2_en;
  logic [1:0]  att_sel;
  logic [1:0]  walk_in;
  logic [1:0]  walk_out;
  logic [31:0] ctl;

  always_comb begin
    next_st = st;
    a64     = st.env[ENV_A64_BIT];
    hyp     = st.env[ENV_HYP_BIT];
    ctl     = st.env[ENV_S2_BIT] ? st.vtcr : st.tcr;

    // ---- bus slave: address and data taken in either order, answer after both
    // each channel moves only at an edge where its valid and ready are both high
    if (AWVALID && AWREADY && !st.aw_hold) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = AWADDR;
    end
    if (WVALID && WREADY && !st.w_hold) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = WDATA;
      next_st.w_strb = WSTRB;
    end
    wr_fire = st.aw_hold && st.w_hold && !st.bvalid;
    wr_addr = st.aw_addr;
    wr_data = st.w_data;
    wr_strb = st.w_strb;
    if (wr_fire) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = is_mapped(wr_addr) ? 2'h0 : 2'h2;
      case (wr_addr)
        OFS_TCR:       next_st.tcr       = merge_strb(st.tcr, wr_data, wr_strb);
        OFS_TBC32:     next_st.tbc       = merge_strb(st.tbc, wr_data, wr_strb);
        OFS_VTCR:      next_st.vtcr      = merge_strb(st.vtcr, wr_data, wr_strb);
        OFS_ENV:       next_st.env       = merge_strb(st.env, wr_data, wr_strb);
        OFS_WALK_ATTR: next_st.walk_attr = merge_strb(st.walk_attr, wr_data, wr_strb);
        OFS_HYP_ATTR:  next_st.hyp_attr  = merge_strb(st.hyp_attr, wr_data, wr_strb);
        OFS_S2_ATTR:   next_st.s2_attr   = merge_strb(st.s2_attr, wr_data, wr_strb);
        default: begin
        end
      endcase
    end
    if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (ARVALID && ARREADY && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = is_mapped(ARADDR) ? 2'h0 : 2'h2;
      case (ARADDR)
        OFS_TCR:        next_st.rdata = st.tcr;
        OFS_TBC32:      next_st.rdata = st.tbc;
        OFS_VTCR:       next_st.rdata = st.vtcr;
        OFS_ENV:        next_st.rdata = st.env;
        OFS_WALK_ATTR:  next_st.rdata = st.walk_attr;
        OFS_HYP_ATTR:   next_st.rdata = st.hyp_attr;
        OFS_S2_ATTR:    next_st.rdata = st.s2_attr;
        OFS_STATUS:     next_st.rdata = {26'h0000000, st.last_fsc};
        OFS_FAULT_ADDR: next_st.rdata = st.fault_addr;
        default:        next_st.rdata = 32'h00000000;
      endcase
    end else if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ---- walk configuration
    // second base register only exists at the lowest privileged level
    if (a64 && st.env[ENV_HIGH_BIT] && st.env[ENV_EL0_BIT] && !st.env[ENV_S2_BIT]) begin
      next_st.walk.gran = mwa_gran_e'(ctl[TCR_GRAN_HI_LSB +: 2]);
    end else begin
      next_st.walk.gran = mwa_gran_e'(ctl[TCR_GRAN_LO_LSB +: 2]);
    end
    if (!a64) begin
      next_st.walk.gran = MWA_G4K;
    end
    if (a64 || hyp) begin
      next_st.walk.long_desc = 1'b1;
    end else begin
      next_st.walk.long_desc = st.env[ENV_SEC_BIT] ? st.tbc[TBC_LDS_S_BIT]
                                                   : st.tbc[TBC_LDS_NS_BIT];
    end
    walk_in  = ctl[TCR_WALK_IN_LSB +: 2];
    walk_out = ctl[TCR_WALK_OUT_LSB +: 2];
    // stage-2 outer attribute of the table itself folds in through REQ.out_rgn
    next_st.walk.walk_cacheable = both_wb(walk_in, walk_out) && st.env[ENV_CACHE_BIT]
                                  && (REQ.out_rgn == RGN_WB || !st.env[ENV_S2_BIT]);
    att_sel = st.env[ENV_S2_BIT] ? st.s2_attr[1:0]
              : (hyp ? st.hyp_attr[1:0] : st.walk_attr[1:0]);
    next_st.walk.walk_pb = att_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // ---- response
    upd_en  = a64 && (st.tcr[TCR_HA_BIT] || st.tcr[TCR_HD_BIT]
                      || st.vtcr[TCR_HA_BIT] || st.vtcr[TCR_HD_BIT]);
    // dirty update even when the access itself fails
    hit_upd = REQ.dirty_mod && (REQ.op != MWA_OP_LOAD)
              && (REQ.ap2 || !REQ.s2ap1);
    upd_req   = upd_en && hit_upd;
    upd_abort = upd_req && !REQ.tbl_wb;

    next_st.rsp.valid  = REQ.valid && (REQ.src != MWA_SRC_NONE);
    next_st.rsp.pa     = REQ.pa;
    next_st.rsp.perm   = REQ.perm;
    next_st.rsp.domain = next_st.walk.long_desc ? 4'h0 : REQ.domain;
    next_st.rsp.ns     = REQ.ns;
    next_st.rsp.upd_s1 = upd_req && !upd_abort && REQ.ap2;
    next_st.rsp.upd_s2 = upd_req && !upd_abort && !REQ.s2ap1;

    next_st.rsp.fault = 1'b1;
    if (REQ.src == MWA_SRC_WALK && REQ.walk_err) begin
      next_st.rsp.fsc = FSC_EXT_ABT;
    end else if (upd_abort) begin
      next_st.rsp.fsc = FSC_UPDATE_ABT;
    end else if (REQ.conflict && REQ.src == MWA_SRC_L1) begin
      next_st.rsp.fsc = FSC_CONFLICT;
    end else if (REQ.addr_size_flt) begin
      next_st.rsp.fsc = FSC_ADDR_SIZE;
    end else if (REQ.trans_flt) begin
      next_st.rsp.fsc = FSC_TRANS;
    end else if (REQ.af_flt) begin
      next_st.rsp.fsc = FSC_ACC_FLAG;
    end else if (REQ.perm_flt) begin
      next_st.rsp.fsc = FSC_PERM;
    end else begin
      next_st.rsp.fault = 1'b0;
      next_st.rsp.fsc   = FSC_NONE;
    end
    // oversize blocks only reach here via REQ.oversize, which never faults
    next_st.rsp.fault_addr = REQ.multi ? REQ.elem_addr : REQ.pa;
    if (REQ.valid && next_st.rsp.fault) begin
      next_st.last_fsc   = next_st.rsp.fsc;
      next_st.fault_addr = next_st.rsp.fault_addr[31:0];
    end

    // ---- memory type handling
    next_st.rsp.bus_type = (REQ.in_type == MWA_MEM_NGNRN) ? MWA_MEM_NGNRN
                           : REQ.in_type;
    next_st.rsp.no_spec  = REQ.in_type[2];
    if (REQ.instr) begin
      next_st.rsp.cacheable = (REQ.in_type == MWA_MEM_WB) || (REQ.in_type == MWA_MEM_WT);
      next_st.rsp.coherent  = (REQ.in_type == MWA_MEM_WB);
    end else begin
      next_st.rsp.cacheable = (REQ.in_type == MWA_MEM_WB) && (REQ.out_rgn == RGN_WB);
      next_st.rsp.coherent  = next_st.rsp.cacheable;
    end

    // ---- page attribute bits
    s1_en = ctl[TCR_PB_LSB +: 2];
    s2_en = st.vtcr[TCR_PB_LSB +: 2];
    for (int b = 0; b < 2; b++) begin
      if (st.env[ENV_S2_BIT]) begin
        next_st.rsp.pb[b] = s2_en[b] ? REQ.s2_pb[b]
                            : (st.tcr[TCR_PB_LSB + b] ? REQ.s1_pb[b] : 1'b0);
      end else begin
        next_st.rsp.pb[b] = s1_en[b] ? REQ.s1_pb[b] : 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      ARREADY <= 1'b0;
    end else begin
      // ready while the holder is free, so a taken item always met ready high
      AWREADY <= !next_st.aw_hold;
      WREADY  <= !next_st.w_hold;
      ARREADY <= !next_st.rvalid;
    end
  end

  assign BVALID  = st.bvalid;
  assign BRESP   = st.bresp;
  assign RVALID  = st.rvalid;
  assign RDATA   = st.rdata;
  assign RRESP   = st.rresp;
  assign RSP     = st.rsp;
  assign WALK    = st.walk;

endmodule
`default_nettype wire

/* dv/mwa_sva.sv */
// checker: lookup response content against the request that caused it
// assumes bind into mwa_top, one clock, RST async active high
`default_nettype none
module mwa_sva
  import mwa_pkg::*;
(
  input wire logic     CLK,
  input wire logic     RST,
  input wire mwa_req_s REQ,
  input wire mwa_rsp_s RSP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  logic hit;
  logic ok;
  assign hit = REQ.valid && REQ.src != MWA_SRC_NONE;
  // write-back tables and no flags, so no higher-priority code can mask the case
  assign ok = hit && REQ.tbl_wb && !REQ.walk_err && !REQ.addr_size_flt && !REQ.trans_flt
      && !REQ.af_flt && !REQ.perm_flt;
  ////////////////////////////////////////
  a_rsp_carries: assert property (hit |=> RSP.valid
      && RSP.pa == $past(REQ.pa) && RSP.ns == $past(REQ.ns))
    else $error("response lost pa or ns");
  a_no_rsp: assert property (!hit |=> !RSP.valid)
    else $error("response without lookup");
  a_ext_abort: assert property (hit && REQ.walk_err |=> RSP.fault && RSP.fsc == FSC_EXT_ABT)
    else $error("walk error not reported as external abort");
  a_multi_addr: assert property (hit && REQ.walk_err && REQ.multi
      |=> RSP.fault_addr == $past(REQ.elem_addr))
    else $error("fault address not the failing element");
  a_oversize_ok: assert property (ok && !REQ.conflict && REQ.oversize
      && REQ.op == MWA_OP_LOAD |=> !RSP.fault)
    else $error("oversize block raised a fault");
  a_l2_conflict: assert property (ok && REQ.conflict && REQ.src == MWA_SRC_L2 |=> !RSP.fault)
    else $error("second-level conflict raised an abort");
  a_l1_conflict: assert property (ok && REQ.conflict && REQ.src == MWA_SRC_L1
      |=> RSP.fault && RSP.fsc == FSC_CONFLICT)
    else $error("first-level conflict not aborted");
  a_data_nocache: assert property (hit && !REQ.instr && REQ.in_type != MWA_MEM_WB
      |=> !RSP.cacheable && !RSP.coherent)
    else $error("non write-back data treated as cacheable");
  a_gather_nospec: assert property (hit && REQ.in_type == MWA_MEM_DEV_GATHER
      |=> RSP.no_spec && !RSP.cacheable)
    else $error("gather-reorder device allows speculation");
  a_strict_bus: assert property (hit && REQ.in_type == MWA_MEM_NGNRN
      |=> RSP.bus_type == MWA_MEM_NGNRN)
    else $error("strict device not reported apart on bus");
  c_ext_multi: cover property (hit && REQ.walk_err && REQ.multi);
  c_l2_conf: cover property (ok && REQ.conflict && REQ.src == MWA_SRC_L2);
  c_strict: cover property (hit && REQ.in_type == MWA_MEM_NGNRN);
endmodule
bind mwa_top mwa_sva mwa_sva_i (.CLK(CLK), .RST(RST), .REQ(REQ), .RSP(RSP));
`default_nettype wire

/* dv/mwa_req_model.sv */
// requester side model: presents one lookup result per go pulse
// assumes go and cmd change just after a rising edge
`default_nettype none
module mwa_req_model
  import mwa_pkg::*;
(
  input  wire logic     CLK,
  input  wire logic     RST,
  input  wire logic     go,
  input  wire mwa_req_s cmd,
  output var  mwa_req_s req
);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      req <= '0;
    end else if (go) begin
      req <= cmd;
    end else begin
      // idle payload toggles so a stale lookup never looks current
      req <= {1'b0, ~req[$bits(mwa_req_s)-2:0]};
    end
  end
endmodule
`default_nettype wire

/* dv/mmu_walk_attr_abort_logic_test.sv */
// bench for mwa_top: register port, walk setup, lookup responses
// assumes mwa_pkg, the requester model and the bound checker
`default_nettype none
module mmu_walk_attr_abort_logic_test import mwa_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        go = 1'b0;
  mwa_req_s    cmd = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  mwa_req_s    req;
  mwa_rsp_s    rsp;
  mwa_walk_s   walk;
  int          compares = 0;
  int          miscompares = 0;
  mwa_gran_e   gl [3] = '{MWA_G4K, MWA_G64K, MWA_G16K};
  logic [31:0] et [4] = '{32'h04, 32'h04, 32'h00, 32'h02};
  logic [31:0] tt [4] = '{32'h1, 32'h2, 32'h2, 32'h0};
  logic [3:0]  lt = 4'hD;
  logic [31:0] ce [3] = '{32'h09, 32'h09, 32'h01};
  logic [31:0] ct [3] = '{32'h50, 32'h60, 32'h50};
  logic [5:0]  ft [4] = '{FSC_ADDR_SIZE, FSC_TRANS, FSC_ACC_FLAG, FSC_PERM};
  mwa_top mwa_top_i (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .REQ(req), .RSP(rsp), .WALK(walk));
  mwa_req_model mwa_req_model_i (.CLK(clk), .RST(rst), .go(go), .cmd(cmd), .req(req));
  ////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    chk("bvalid", 1'b1, bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    chk("rvalid", 1'b1, rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // walk config lags the register by one cycle
  task automatic cfg(input logic [31:0] e, input logic [7:0] o, input logic [31:0] v);
    wr(OFS_ENV, e, 2'h0);
    wr(o, v, 2'h0);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic look(input mwa_req_s r);
    @(posedge clk);
    cmd <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    mwa_req_s    b;
    mwa_req_s    r;
    logic [31:0] d;
    logic [1:0]  s;
    b = '0;
    b.valid = 1'b1;
    b.src = MWA_SRC_L1;
    b.pa = 40'h12_3456_7000;
    b.perm = 3'h5;
    b.ns = 1'b1;
    b.tbl_wb = 1'b1;
    b.out_rgn = RGN_WB;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h40, d, s);
    chk("unmapped_rresp", 2'h2, s);
    wr(8'h40, 32'h1, 2'h2);
    for (int i = 0; i < 3; i++) begin
      cfg(32'h01, OFS_TCR, {30'h0, gl[i]});
      chk("gran", gl[i], walk.gran);
    end
    cfg(32'h31, OFS_TCR, 32'h04);
    chk("gran_high", MWA_G64K, walk.gran);
    cfg(32'h11, OFS_TCR, 32'h04);
    chk("gran_not_el0", MWA_G4K, walk.gran);
    for (int i = 0; i < 4; i++) begin
      cfg(et[i], OFS_TBC32, tt[i]);
      chk("long_desc", lt[i], walk.long_desc);
    end
    for (int i = 0; i < 3; i++) begin
      cfg(ce[i], OFS_TCR, ct[i]);
      chk("walk_cache", i == 0, walk.walk_cacheable);
    end
    cfg(32'h01, OFS_WALK_ATTR, 32'h2);
    chk("walk_pb", 2'h2, walk.walk_pb);
    cfg(32'h02, OFS_HYP_ATTR, 32'h1);
    chk("hyp_walk_pb", 2'h1, walk.walk_pb);
    cfg(32'h40, OFS_S2_ATTR, 32'h3);
    chk("s2_walk_pb", 2'h3, walk.walk_pb);
    cfg(32'h09, OFS_TCR, 32'h350);
    for (int i = 1; i < 4; i++) begin
      r = b;
      r.src = mwa_src_e'(i);
      look(r);
      chk("pa", b.pa, rsp.pa);
      chk("perm", b.perm, rsp.perm);
      chk("no_fault", 1'b0, rsp.fault);
      chk("rsp_valid", 1'b1, rsp.valid);
      chk("ns", b.ns, rsp.ns);
    end
    for (int i = 0; i < 4; i++) begin
      r = b;
      {r.addr_size_flt, r.trans_flt, r.af_flt, r.perm_flt} = 4'h8 >> i;
      look(r);
      chk("fsc", ft[i], rsp.fsc);
      chk("fault", 1'b1, rsp.fault);
    end
    r = b;
    r.src = MWA_SRC_WALK;
    r.walk_err = 1'b1;
    r.multi = 1'b1;
    r.elem_addr = 40'h00_8765_4328;
    look(r);
    chk("fsc_ext", FSC_EXT_ABT, rsp.fsc);
    chk("fault_addr", r.elem_addr, rsp.fault_addr);
    rd(OFS_FAULT_ADDR, d, s);
    chk("fault_addr_reg", 32'h8765_4328, d);
    rd(OFS_STATUS, d, s);
    chk("status_reg", FSC_EXT_ABT, d);
    r = b;
    r.oversize = 1'b1;
    look(r);
    chk("oversize", 1'b0, rsp.fault);
    r = b;
    r.conflict = 1'b1;
    look(r);
    chk("l1_conflict", FSC_CONFLICT, rsp.fsc);
    r.src = MWA_SRC_L2;
    look(r);
    chk("l2_conflict", 1'b0, rsp.fault);
    r = b;
    r.op = MWA_OP_STR;
    r.dirty_mod = 1'b1;
    r.ap2 = 1'b1;
    r.tbl_wb = 1'b0;
    for (int i = 0; i < 2; i++) begin
      r.instr = i[0];
      look(r);
      chk("fsc_upd", FSC_UPDATE_ABT, rsp.fsc);
    end
    cfg(32'h08, OFS_TCR, 32'h350);
    look(r);
    chk("upd_a32", 1'b0, rsp.fault);
    cfg(32'h09, OFS_TCR, 32'h50);
    look(r);
    chk("upd_off", 1'b0, rsp.fault);
    cfg(32'h49, OFS_VTCR, 32'h350);
    cfg(32'h49, OFS_TCR, 32'h350);
    for (int i = 1; i < 7; i++) begin
      r = b;
      r.op = mwa_op_e'(i % 3 + 1);
      r.dirty_mod = 1'b1;
      r.op_fail = 1'b1;
      r.ap2 = i < 4;
      r.s2ap1 = i < 4;
      look(r);
      chk("upd_s1", i < 4, rsp.upd_s1);
      chk("upd_s2", i > 3, rsp.upd_s2);
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 3) continue;
      r = b;
      r.in_type = mwa_mem_e'(i);
      look(r);
      chk("cacheable", i == 0, rsp.cacheable);
      chk("coherent", i == 0, rsp.coherent);
      if (i == 4) chk("no_spec", 1'b1, rsp.no_spec);
      if (i > 3) chk("bus_type", i[2:0], rsp.bus_type);
    end
    r = b;
    r.instr = 1'b1;
    r.in_type = MWA_MEM_WT;
    look(r);
    chk("instr_wt_cache", 1'b1, rsp.cacheable);
    chk("instr_wt_coh", 1'b0, rsp.coherent);
    r = b;
    r.s1_pb = 2'h3;
    r.s2_pb = 2'h0;
    look(r);
    chk("pb_off", 2'h0, rsp.pb);
    cfg(32'h09, OFS_TCR, 32'h750);
    look(r);
    chk("pb_one", 2'h1, rsp.pb);
    cfg(32'h49, OFS_TCR, 32'hF50);
    cfg(32'h49, OFS_VTCR, 32'hB50);
    look(r);
    chk("pb_two", 2'h1, rsp.pb);
    end_sim();
  end
endmodule
`default_nettype wire
